// ---- hw/spcru_map.vh ----
// Function
// - Power resets leave monitor on and selected
// - Low supply drives pin and holds core
// - Power-fail reset sets flag, RAM invalid
// - Only power resets change monitor state
// - Sleep suppresses power-fail reset generation
// - Monitor settings hold through sleep, waking needs no restore
// - Warning bit clears at threshold, interrupt
// - Flash write with monitor off resets
// - No power-on delay after monitor reset
// - Bit 7 monitor on, resets to one
// - Bits 6 and 5 show comparisons
// - Bits 4:0 read zero, writes ignored
// - Low pin resets, also in sleep
// - Pin reset sets cause bit zero
// - Stalled clock past timeout causes reset
// - Bit 2 reads one after clock loss
// - Writing bit 2 enables clock detector
// - Low power gates detector, keeps enable
// - Clock loss reset leaves pin alone
// - Bit 1 is power flag and select
`ifndef SPCRU_MAP_VH
`define SPCRU_MAP_VH

// Register addresses
`define SPCRU_ADDR_MON_CTRL    8'hff
`define SPCRU_ADDR_RST_CAUSE   8'hef

// Monitor control fields
`define SPCRU_MON_ON_BIT       7
`define SPCRU_ABOVE_RST_BIT    6
`define SPCRU_EARLY_WARN_BIT   5

// Reset cause fields
`define SPCRU_PIN_FLAG_BIT     0
`define SPCRU_PWR_FLAG_BIT     1
`define SPCRU_CLK_LOSS_BIT     2
`define SPCRU_SOFT_BIT         4
`define SPCRU_FLASH_ERR_BIT    6

// Reset values
`define SPCRU_MON_ON_RST       1'b1
`define SPCRU_PWR_SEL_RST      1'b1
`define SPCRU_CLK_LOSS_EN_RST  1'b0

// Timing
`define SPCRU_CLK_PERIOD_NS    8
`define SPCRU_CLK_LOSS_NS      100000
`define SPCRU_CLK_LOSS_CYC     ((`SPCRU_CLK_LOSS_NS + `SPCRU_CLK_PERIOD_NS - 1) / `SPCRU_CLK_PERIOD_NS)
`define SPCRU_POR_DLY_CYC      16
`define SPCRU_MIN_HOLD_CYC     8

`endif

// ---- hw/spcru_top.v ----
`timescale 1ns/100ps
`default_nettype none
`include "spcru_map.vh"

module spcru_top #(
  parameter CLK_LOSS_CYC = `SPCRU_CLK_LOSS_CYC, // Stall timeout in cycles
  parameter POR_DLY_CYC  = `SPCRU_POR_DLY_CYC,  // Power-on release delay
  parameter MIN_HOLD_CYC = `SPCRU_MIN_HOLD_CYC, // Least reset length
  parameter CNT_W        = 16                   // Counter width
) (
  input  wire       i_clk,            // System clock
  input  wire       i_nrst,           // Power-on reset, active low
  input  wire [7:0] i_sfr_addr,       // Register address
  input  wire       i_sfr_wr,         // Register write strobe
  input  wire [7:0] i_sfr_wdata,      // Register write data
  output wire [7:0] o_sfr_rdata,      // Register read data
  input  wire       i_cmp_above_rst,  // Supply above reset level
  input  wire       i_cmp_above_warn, // Supply above warning level
  input  wire       i_rst_pin_n,      // Reset pin level, low active
  input  wire       i_sysclk_mon,     // Watched system clock
  input  wire       i_sleep,          // Sleep mode
  input  wire       i_suspend,        // Suspend mode
  input  wire       i_flash_wr,       // Flash write or erase try
  output wire       o_rst_pin_out,    // Pin drive level
  output wire       o_rst_pin_oe,     // Pin drive enable
  output wire       o_core_rst,       // Core held in reset
  output wire       o_mon_on,         // Supply monitor switched on
  output wire       o_warn_irq,       // Early warning event pulse
  output wire       o_ram_invalid     // RAM contents not trusted
);

  // Sequencer states
  localparam ST_POR  = 2'd0;
  localparam ST_RUN  = 2'd1;
  localparam ST_HOLD = 2'd2;

  // Reset causes
  localparam C_PWR = 3'd0;
  localparam C_PIN = 3'd1;
  localparam C_CLK = 3'd2;
  localparam C_FLS = 3'd3;
  localparam C_SW  = 3'd4;

  reg  [1:0]       state_reg;        // Sequencer state
  reg  [1:0]       state_next;
  reg  [2:0]       cause_reg;        // Cause of current reset
  reg  [2:0]       cause_next;
  reg  [CNT_W-1:0] hold_cnt_reg;     // Reset length counter
  reg  [CNT_W-1:0] hold_cnt_next;
  reg  [CNT_W-1:0] stall_cnt_reg;    // Cycles since clock edge
  reg              mon_on_reg;       // Monitor switched on
  reg              pwr_sel_reg;      // Monitor selected as source
  reg              clk_en_reg;       // Clock loss detector enable
  reg              soft_req_reg;     // Software reset request
  reg              fls_req_reg;      // Flash error request
  reg              pin_flag_reg;     // Cause flags
  reg              pwr_flag_reg;
  reg              clk_flag_reg;
  reg              sw_flag_reg;
  reg              fls_flag_reg;
  reg  [1:0]       above_rst_sync;   // Comparator synchronisers
  reg  [1:0]       above_warn_sync;
  reg  [1:0]       pin_sync;         // Pin synchroniser
  reg  [2:0]       mon_sync;         // Watched clock, last is history
  reg  [2:0]       drive_dly_reg;    // Own pin drive, delayed
  reg              warn_d_reg;       // Warning level, last cycle
  reg              irq_reg;          // Early warning pulse
  reg              core_rst_reg;     // Core reset output
  reg              pin_oe_reg;       // Pin drive output
  reg  [7:0]       rdata_reg;        // Read data output

  wire above_rst  = above_rst_sync[1];
  wire above_warn = above_warn_sync[1];
  wire pin_low    = ~pin_sync[1];
  wire low_power  = i_sleep | i_suspend;

  // Address decode, shared by write strobe and read mux
  function hit_mon;
    input [7:0] addr;
    hit_mon = (addr == `SPCRU_ADDR_MON_CTRL);
  endfunction

  // Same for the reset cause register
  function hit_rc;
    input [7:0] addr;
    hit_rc = (addr == `SPCRU_ADDR_RST_CAUSE);
  endfunction

  // Comparator and pin synchronisers
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // Idle levels: supply good, pin released, no false edge
      above_rst_sync  <= 2'h3;
      above_warn_sync <= 2'h3;
      pin_sync        <= 2'h3;
      mon_sync        <= 3'h0;
    end else begin
      // Pins are asynchronous; two flops before any use
      above_rst_sync  <= {above_rst_sync[0], i_cmp_above_rst};
      above_warn_sync <= {above_warn_sync[0], i_cmp_above_warn};
      pin_sync        <= {pin_sync[0], i_rst_pin_n};
      // Watched clock keeps a third flop as edge history
      mon_sync        <= {mon_sync[1:0], i_sysclk_mon};
    end
  end

  // Supply reset only when on, selected and awake
  // Sleep drops this source but keeps RAM; suspend does not
  wire pwr_src = mon_on_reg & pwr_sel_reg & ~above_rst
                 & ~i_sleep;

  // Our own drive loops back through the sync; mask it out
  // Limitation: an outside pulse inside the mask window is lost
  wire pin_src = pin_low & ~pin_oe_reg
                 & ~(|drive_dly_reg);

  // Stall detector gated in low power, enable kept
  // Edges are seen on the synced copy, a few cycles late
  wire clk_act  = clk_en_reg & ~low_power;
  wire clk_edge = mon_sync[2] ^ mon_sync[1];
  wire clk_src  = clk_act &
                  (stall_cnt_reg >= CLK_LOSS_CYC[CNT_W-1:0]);

  // Stall counter
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stall_cnt_reg <= {CNT_W{1'b0}};
    end else if (!clk_act || clk_edge || state_reg != ST_RUN) begin
      // Any edge, gate or reset in progress restarts the count
      stall_cnt_reg <= {CNT_W{1'b0}};
    end else if (!clk_src) begin
      // Stops at the timeout so the count cannot wrap
      stall_cnt_reg <= stall_cnt_reg + 1'b1;
    end
  end

  // Register write decode
  // Writes while in reset are dropped, not queued
  wire wr_ok  = i_sfr_wr & (state_reg == ST_RUN);
  wire wr_mon = wr_ok & hit_mon(i_sfr_addr);
  wire wr_rc  = wr_ok & hit_rc(i_sfr_addr);

  // Sequencer next state
  always @* begin
    state_next    = state_reg;
    cause_next    = cause_reg;
    hold_cnt_next = hold_cnt_reg;
    case (state_reg)
      ST_POR: begin
        // Power-on release delay
        // Pin stays pulled and core held meanwhile
        if (hold_cnt_reg >= POR_DLY_CYC[CNT_W-1:0]) begin
          state_next    = ST_RUN;
          hold_cnt_next = {CNT_W{1'b0}};
        end else begin
          hold_cnt_next = hold_cnt_reg + 1'b1;
        end
      end
      ST_RUN: begin
        hold_cnt_next = {CNT_W{1'b0}};
        // Priority: supply, pin, clock, flash, software
        if (pwr_src) begin
          // Supply below reset level
          state_next = ST_HOLD;
          cause_next = C_PWR;
        end else if (pin_src) begin
          // Outside circuit pulls the pin
          state_next = ST_HOLD;
          cause_next = C_PIN;
        end else if (clk_src) begin
          // Watched clock stalled
          state_next = ST_HOLD;
          cause_next = C_CLK;
        end else if (fls_req_reg) begin
          // Flash touched with monitor off
          state_next = ST_HOLD;
          cause_next = C_FLS;
        end else if (soft_req_reg) begin
          // Software asked for a reset
          state_next = ST_HOLD;
          cause_next = C_SW;
        end
      end
      ST_HOLD: begin
        // Minimum hold first, then wait for the source to clear
        if (hold_cnt_reg < MIN_HOLD_CYC[CNT_W-1:0]) begin
          hold_cnt_next = hold_cnt_reg + 1'b1;
        end else if (cause_reg == C_PWR) begin
          // Release once supply back; no extra delay
          if (above_rst) begin
            state_next = ST_RUN;
          end
        end else if (cause_reg == C_PIN) begin
          // Held for as long as the pin stays low
          if (!pin_low) begin
            state_next = ST_RUN;
          end
        end else begin
          // Clock, flash and software sources need no wait
          state_next = ST_RUN;
        end
      end
      default: begin
        // Unused code, fall back to power-on
        state_next = ST_POR;
      end
    endcase
  end

  // Exit strobes for the flag and setting updates
  wire leaving = (state_reg == ST_HOLD) && (state_next == ST_RUN);
  wire por_out = (state_reg == ST_POR) && (state_next == ST_RUN);

  // Sequencer registers
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // Power-on starts the release delay
      state_reg    <= ST_POR;
      cause_reg    <= C_PWR;
      hold_cnt_reg <= {CNT_W{1'b0}};
    end else begin
      state_reg    <= state_next;
      cause_reg    <= cause_next;
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  // Monitor on, select, detector enable, requests
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // Power-on: monitor on and selected, detector off
      mon_on_reg   <= `SPCRU_MON_ON_RST;
      pwr_sel_reg  <= `SPCRU_PWR_SEL_RST;
      clk_en_reg   <= `SPCRU_CLK_LOSS_EN_RST;
      soft_req_reg <= 1'b0;
      fls_req_reg  <= 1'b0;
    end else begin
      if (leaving && cause_reg == C_PWR) begin
        // Only power resets touch these two
        mon_on_reg  <= 1'b1;
        pwr_sel_reg <= 1'b1;
      end else if (wr_mon) begin
        // Settings hold through sleep, so waking needs no restore
        mon_on_reg  <= i_sfr_wdata[`SPCRU_MON_ON_BIT];
      end else if (wr_rc) begin
        // Select bit shares its place with the power flag
        pwr_sel_reg <= i_sfr_wdata[`SPCRU_PWR_FLAG_BIT];
      end
      // Detector enable kept over every reset but power-on
      if (wr_rc) begin
        clk_en_reg <= i_sfr_wdata[`SPCRU_CLK_LOSS_BIT];
      end
      // Requests live until the sequencer takes them
      if (state_reg == ST_HOLD) begin
        soft_req_reg <= 1'b0;
        fls_req_reg  <= 1'b0;
      end else begin
        if (wr_rc && i_sfr_wdata[`SPCRU_SOFT_BIT]) begin
          soft_req_reg <= 1'b1;
        end
        if (i_flash_wr && !mon_on_reg && state_reg == ST_RUN) begin
          fls_req_reg <= 1'b1;
        end
      end
    end
  end

  // Cause flags, written on the way out of reset
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // Power flag stands from the start
      pin_flag_reg <= 1'b0;
      pwr_flag_reg <= 1'b1;
      clk_flag_reg <= 1'b0;
      sw_flag_reg  <= 1'b0;
      fls_flag_reg <= 1'b0;
    end else if (por_out) begin
      // Power-on: only the power flag is set
      pwr_flag_reg <= 1'b1;
      pin_flag_reg <= 1'b0;
      clk_flag_reg <= 1'b0;
      sw_flag_reg  <= 1'b0;
      fls_flag_reg <= 1'b0;
    end else if (leaving) begin
      // Exactly one flag, for the source just left
      pwr_flag_reg <= (cause_reg == C_PWR);
      pin_flag_reg <= (cause_reg == C_PIN);
      clk_flag_reg <= (cause_reg == C_CLK);
      sw_flag_reg  <= (cause_reg == C_SW);
      fls_flag_reg <= (cause_reg == C_FLS);
    end
  end

  // Outputs: core reset, pin drive, warning pulse
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // Power-on holds the core and pulls the pin
      core_rst_reg  <= 1'b1;
      pin_oe_reg    <= 1'b1;
      drive_dly_reg <= 3'h7;
      warn_d_reg    <= 1'b1;
      irq_reg       <= 1'b0;
    end else begin
      // Taken from next state so the output is not a cycle late
      core_rst_reg  <= (state_next != ST_RUN);
      // Pin pulled only by power-on and supply resets
      pin_oe_reg    <= (state_next == ST_POR) ||
                       (state_next == ST_HOLD && cause_next == C_PWR);
      // History of our own drive, for the pin mask
      drive_dly_reg <= {drive_dly_reg[1:0], pin_oe_reg};
      // Fall of the synced warning level gives one pulse
      warn_d_reg    <= above_warn;
      irq_reg       <= warn_d_reg & ~above_warn;
    end
  end

  // Read mux, one cycle latency; unmapped reads zero
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg <= 8'h00;
    end else if (hit_mon(i_sfr_addr)) begin
      // Low five bits always zero
      rdata_reg <= {mon_on_reg, above_rst, above_warn,
                    5'h00};
    end else if (hit_rc(i_sfr_addr)) begin
      // Flags only; enables are not shown here
      rdata_reg <= {1'b0, fls_flag_reg, 1'b0, sw_flag_reg, 1'b0,
                    clk_flag_reg, pwr_flag_reg, pin_flag_reg};
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // Every output but the fixed pin level comes from a flop
  assign o_sfr_rdata   = rdata_reg;
  assign o_rst_pin_out = 1'b0;          // Open drain, only ever low
  assign o_rst_pin_oe  = pin_oe_reg;
  assign o_core_rst    = core_rst_reg;
  assign o_mon_on      = mon_on_reg;
  assign o_warn_irq    = irq_reg;
  assign o_ram_invalid = pwr_flag_reg;

endmodule

`default_nettype wire

// ---- sim/spcru_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module spcru_monitor (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       i_cmp_above_rst,
  input wire logic       i_cmp_above_warn,
  input wire logic       i_sleep,
  input wire logic       i_flash_wr,
  input wire logic       o_rst_pin_out,
  input wire logic       o_rst_pin_oe,
  input wire logic       o_core_rst,
  input wire logic       o_mon_on,
  input wire logic       o_warn_irq,
  input wire logic       o_ram_invalid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Supply low long enough to clear the synchronisers
  sequence s_fail;
    (o_mon_on && !i_sleep && !i_cmp_above_rst)[*6];
  endsequence
  // Supply back up after a pulled reset
  sequence s_back;
    $rose(i_cmp_above_rst) && o_rst_pin_oe ##1 i_cmp_above_rst[*6];
  endsequence
  chk_fail_pulls: assert property (s_fail |-> o_rst_pin_oe && o_core_rst)
    else $error("pin not pulled on low supply");
  chk_drive_low: assert property (o_rst_pin_oe |-> o_core_rst && o_rst_pin_out == 1'b0)
    else $error("pin driven high");
  chk_oe_cause: assert property ($rose(o_rst_pin_oe) |-> !$past(i_cmp_above_rst, 2))
    else $error("pin pulled without supply fail");
  chk_sleep_gate: assert property (i_sleep[*4] |-> !$rose(o_rst_pin_oe))
    else $error("power fail reset in sleep");
  chk_quick_exit: assert property (s_back |-> ##[0:6] !o_core_rst)
    else $error("release delayed after supply reset");
  chk_warn_irq: assert property ($fell(i_cmp_above_warn) |-> ##[1:6] o_warn_irq)
    else $error("no warning event");
  chk_warn_pulse: assert property ($rose(o_warn_irq) |-> ##1 !o_warn_irq)
    else $error("warning event too long");
  chk_power_exit: assert property ($fell(o_core_rst) && o_ram_invalid |-> o_mon_on)
    else $error("monitor off after power reset");
  chk_flash_err: assert property (i_flash_wr && !o_mon_on && !o_core_rst |-> ##[1:4] o_core_rst)
    else $error("no flash error reset");
  chk_read_layout: assert property ($past(i_sfr_addr) == 8'hff && !$past(o_core_rst)
    && !o_core_rst |-> o_sfr_rdata[7] == $past(o_mon_on) && o_sfr_rdata[4:0] == 5'h00)
    else $error("control read layout wrong");
endmodule
`default_nettype wire

// ---- sim/spcru_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// Far side: pulled-up reset pin and the two supply comparators
module spcru_partner (
  input  wire logic i_oe,        // Device pulls pin
  input  wire logic i_out,       // Device drive level
  input  wire logic i_ext_low,   // Outside circuit asserts reset
  input  wire logic i_sup_ok,    // Supply above reset level
  input  wire logic i_warn_ok,   // Supply above warning level
  output wire logic o_pin_n,     // Resolved pin level
  output wire logic o_above_rst, // Reset comparator
  output wire logic o_above_warn // Warning comparator
);
  // Pull-up wins unless someone pulls low
  assign o_pin_n = ((i_oe && !i_out) || i_ext_low) ? 1'b0 : 1'b1;
  // Comparators follow the supply model
  assign o_above_rst = i_sup_ok;
  assign o_above_warn = i_warn_ok;
endmodule
`default_nettype wire

// ---- sim/spcru_top_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module spcru_top_bench;
  localparam int LOSS = 50; // Short stall timeout for sim
  logic i_clk = 1'b0, i_nrst = 1'b0, i_sfr_wr = 1'b0, i_flash_wr = 1'b0;
  logic i_sleep = 1'b0, i_suspend = 1'b0, i_sysclk_mon = 1'b0, clk_run = 1'b1;
  logic ext_low = 1'b0, sup_ok = 1'b1, warn_ok = 1'b1, mon_m = 1'b1, seen, pin;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
  logic [31:0] lfsr = 32'h3c1a;
  wire logic [7:0] o_sfr_rdata;
  wire logic i_cmp_above_rst, i_cmp_above_warn, i_rst_pin_n, o_rst_pin_out, o_rst_pin_oe;
  wire logic o_core_rst, o_mon_on, o_warn_irq, o_ram_invalid;
  int fails = 0, n_compared = 0, irqs, k;
  always #4 i_clk = ~i_clk;
  // Watched clock toggles every cycle unless stalled
  always @(posedge i_clk) i_sysclk_mon <= #1 clk_run ^ i_sysclk_mon;
  spcru_top #(.CLK_LOSS_CYC(LOSS)) u_dut (.*);
  spcru_partner u_far (.i_oe(o_rst_pin_oe), .i_out(o_rst_pin_out), .i_ext_low(ext_low),
    .i_sup_ok(sup_ok), .i_warn_ok(warn_ok), .o_pin_n(i_rst_pin_n),
    .o_above_rst(i_cmp_above_rst), .o_above_warn(i_cmp_above_warn));
  // Next state of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp);
    n_compared++;
    if (seen_v !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen_v, exp);
    end
  endtask
  // Write strobe is a single cycle, then one idle edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    if (a == 8'hff) mon_m = d[7];
    tick(1);
    i_sfr_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_sfr_addr = a;
    tick(1);
    check(o_sfr_rdata, a == 8'hff ? {mon_m, sup_ok, warn_ok, 5'h00} : exp);
  endtask
  // Bounded wait for the core to leave reset
  task automatic wait_run;
    tick(3);
    for (k = 0; o_core_rst !== 1'b0 && k < 400; k++) tick(1);
    if (k >= 400) fails++;
    tick(2);
  endtask
  task automatic stall(input int n);
    seen = 1'b0;
    pin = 1'b0;
    clk_run = 1'b0;
    for (k = 0; k < n; k++) begin
      tick(1);
      seen = seen | o_core_rst;
      pin = pin | o_rst_pin_oe;
    end
    clk_run = 1'b1;
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    tick(12);
    i_nrst = 1'b1;
    wait_run();
    check(8'(o_ram_invalid), 8'h01);
    rd(8'hff, 8'h00);
    rd(8'hef, 8'h02);
    // Random junk in ignored bits and to unmapped places
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(8'hff, {1'b1, lfsr[6:5], 3'b000, lfsr[1:0]});
      rd(8'hff, 8'h00);
      wr({1'b0, lfsr[14:8]} | 8'h01, lfsr[23:16]);
      rd(i_sfr_addr, 8'h00);
    end
    warn_ok = 1'b0;
    irqs = 0;
    for (k = 0; k < 8; k++) begin
      tick(1);
      irqs += (o_warn_irq !== 1'b0);
    end
    check(8'(irqs), 8'h01);
    rd(8'hff, 8'h00);
    warn_ok = 1'b1;
    // Pin reset taken while asleep, pin never driven by us
    i_sleep = 1'b1;
    ext_low = 1'b1;
    tick(10);
    check(8'({o_core_rst, o_rst_pin_oe}), 8'h02);
    ext_low = 1'b0;
    i_sleep = 1'b0;
    wait_run();
    rd(8'hef, 8'h01);
    check(8'(o_ram_invalid), 8'h00);
    wr(8'hef, 8'h06);
    i_suspend = 1'b1;
    stall(LOSS + 30);
    check(8'(seen), 8'h00);
    i_suspend = 1'b0;
    tick(2);
    stall(LOSS + 10);
    check(8'({seen, pin}), 8'h02);
    wait_run();
    rd(8'hef, 8'h04);
    wr(8'hef, 8'h02);
    stall(LOSS + 30);
    check(8'(seen), 8'h00);
    // Monitor off survives a software reset, then flash trips
    wr(8'hff, 8'h00);
    wr(8'hef, 8'h12);
    wait_run();
    rd(8'hff, 8'h00);
    rd(8'hef, 8'h10);
    i_flash_wr = 1'b1;
    tick(1);
    i_flash_wr = 1'b0;
    wait_run();
    rd(8'hef, 8'h40);
    wr(8'hff, 8'h80);
    tick(20);
    wr(8'hef, 8'h02);
    i_sleep = 1'b1;
    sup_ok = 1'b0;
    tick(30);
    check(8'(o_rst_pin_oe), 8'h00);
    sup_ok = 1'b1;
    tick(5);
    i_sleep = 1'b0;
    rd(8'hff, 8'h00);
    sup_ok = 1'b0;
    tick(20);
    check(8'({o_core_rst, o_rst_pin_oe}), 8'h03);
    sup_ok = 1'b1;
    wait_run();
    rd(8'hef, 8'h02);
    check(8'(o_ram_invalid), 8'h01);
    tally_and_finish();
  end
  // Watchdog well past the expected run length
  initial begin
    #(8 * 5000);
    fails++;
    tally_and_finish();
  end
endmodule
bind spcru_top spcru_monitor u_mon (.*);
`default_nettype wire
